// ==== src/wkd_defs.svh ====
// Constants of the wake-up and interrupt dispatch block.
// Assumes inclusion by bare name from every file that needs them.
`ifndef WKD_DEFS_SVH
`define WKD_DEFS_SVH

`define WKD_NSRC      6
`define WKD_MASK_RST  1'b1
`define WKD_PULSE_RST 1'b0

`endif

// ==== src/wkd_pkg.sv ====
// Types of the wake-up and interrupt dispatch block.
// Assumes wkd_defs.svh is on the include path.
`include "wkd_defs.svh"

package wkd_pkg;

	// ----------------------------------------------------------------
	// Power modes and wake sources
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		WKD_SLEEP,
		WKD_IDLE,
		WKD_GREEN,
		WKD_NORMAL
	} wkd_mode_e;

	typedef enum logic [2:0] {
		WKD_SRC_PIN,
		WKD_SRC_LVD,
		WKD_SRC_CONV,
		WKD_SRC_I2C,
		WKD_SRC_SPI,
		WKD_SRC_SCAN
	} wkd_src_e;

	typedef logic [`WKD_NSRC-1:0] wkd_vec_t;

endpackage : wkd_pkg

// ==== src/wkd_dec_if.sv ====
// Carrier between the dispatch top and its per-source decoder.
// Assumes one clock domain; the decoder is purely combinational.
`timescale 1ns/10ps
`default_nettype none

interface wkd_dec_if;
	import wkd_pkg::*;

	wkd_mode_e mode;
	logic      masked;
	wkd_vec_t  evt;
	wkd_vec_t  wake_en;
	wkd_vec_t  irq_en;
	wkd_vec_t  wake;
	wkd_vec_t  vec;

	modport ctrl (
		output mode, masked, evt, wake_en, irq_en,
		input  wake, vec
	);

	modport dec (
		input  mode, masked, evt, wake_en, irq_en,
		output wake, vec
	);

endinterface : wkd_dec_if

`default_nettype wire

// ==== src/wkd_src_dec.sv ====
// Per-source decision: wake from low power and/or take the vector.
// Assumes events are one-cycle pulses from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none

`include "wkd_defs.svh"

module wkd_src_dec
	import wkd_pkg::*;
(
	// Decision carrier
	wkd_dec_if.dec bus
);

	// ----------------------------------------------------------------
	// Decision table
	// ----------------------------------------------------------------
	// Returns {wake, vector} for one source with an event present
	function automatic logic [1:0] wkd_decide(
		input wkd_src_e  src,
		input logic      we,
		input logic      ie,
		input wkd_mode_e mode,
		input logic      masked
	);
		logic low;
		logic wk;
		logic vc;
		low = (mode == WKD_SLEEP) || (mode == WKD_IDLE);
		wk  = 1'b0;
		vc  = 1'b0;
		case (src)
			WKD_SRC_SCAN: begin
				if (we) begin
					wk = low;
					vc = ie && !masked && (mode != WKD_SLEEP);
				end
			end
			WKD_SRC_LVD: begin
				wk = low && we;
				vc = !low && ie && !masked;
			end
			WKD_SRC_I2C: begin
				if (mode != WKD_GREEN) begin
					wk = low && we;
					vc = ie && !masked && (we || !low);
				end
			end
			default: begin
				wk = low && we;
				vc = ie && !masked && (we || !low);
			end
		endcase
		wkd_decide = {wk, vc};
	endfunction : wkd_decide

	// ----------------------------------------------------------------
	// Evaluation of all sources
	// ----------------------------------------------------------------
	always_comb begin
		logic [1:0] r;
		r        = 2'h0;
		bus.wake = '0;
		bus.vec  = '0;
		for (int i = 0; i < `WKD_NSRC; i++) begin
			r = wkd_decide(wkd_src_e'(i[2:0]), bus.wake_en[i],
				bus.irq_en[i], bus.mode, bus.masked);
			bus.wake[i] = bus.evt[i] && r[1];
			bus.vec[i]  = bus.evt[i] && r[0];
		end
	end

endmodule : wkd_src_dec

`default_nettype wire

// ==== src/wkd_top.sv ====
// Wake-up and interrupt dispatch between peripheral events and the core.
// Assumes all event and instruction strobes are one-cycle pulses on
// clk_sys_i; the power mode comes from the core sequencer.
`timescale 1ns/10ps
`default_nettype none

`include "wkd_defs.svh"

module wkd_top
	import wkd_pkg::*;
(
	// Clock and reset
	input  wire logic      clk_sys_i,
	input  wire logic      rst_i,
	// Core state and instructions
	input  wire wkd_mode_e power_mode_i,
	input  wire logic      global_irq_mask_instr_i,
	input  wire logic      global_irq_unmask_instr_i,
	// Enables
	input  wire logic      pin_change_wake_en_i,
	input  wire logic      pin_change_irq_en_i,
	input  wire logic      low_volt_wake_en_i,
	input  wire logic      low_volt_irq_en_i,
	input  wire logic      conv_done_wake_en_i,
	input  wire logic      conv_done_irq_en_i,
	input  wire logic      i2c_slave_wake_en_i,
	input  wire logic      i2c_irq_en_i,
	input  wire logic      spi_slave_wake_en_i,
	input  wire logic      spi_irq_en_i,
	input  wire logic      idle_scan_en_i,
	input  wire logic      scan_irq_en_i,
	// Events
	input  wire logic      pin_change_evt_i,
	input  wire logic      low_volt_evt_i,
	input  wire logic      conv_done_evt_i,
	input  wire logic      i2c_slave_evt_i,
	input  wire logic      spi_slave_evt_i,
	input  wire logic      scan_evt_i,
	input  wire logic      watchdog_timer_timeout_i,
	// To the core sequencer
	output logic           wake_o,
	output logic           vector_o,
	output wkd_vec_t       wake_src_o,
	output wkd_vec_t       vec_src_o,
	output logic           reset_req_o,
	output logic           irq_masked_o,
	output logic           osc_hold_o,
	output logic           i2c_avail_o
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic     masked_reg;
	logic     wake_reg;
	logic     vector_reg;
	wkd_vec_t wake_src_reg;
	wkd_vec_t vec_src_reg;
	logic     reset_req_reg;
	logic     osc_hold_reg;
	logic     i2c_avail_reg;
	wkd_vec_t wake_src_next;
	wkd_vec_t vec_src_next;

	wkd_dec_if dec_bus ();

	// ----------------------------------------------------------------
	// Decoder hookup
	// ----------------------------------------------------------------
	assign dec_bus.mode    = power_mode_i;
	assign dec_bus.masked  = masked_reg;
	assign dec_bus.evt     = {scan_evt_i, spi_slave_evt_i, i2c_slave_evt_i,
		conv_done_evt_i, low_volt_evt_i, pin_change_evt_i};
	assign dec_bus.wake_en = {idle_scan_en_i, spi_slave_wake_en_i,
		i2c_slave_wake_en_i, conv_done_wake_en_i, low_volt_wake_en_i,
		pin_change_wake_en_i};
	assign dec_bus.irq_en  = {scan_irq_en_i, spi_irq_en_i, i2c_irq_en_i,
		conv_done_irq_en_i, low_volt_irq_en_i, pin_change_irq_en_i};

	wkd_src_dec u_dec (
		.bus (dec_bus.dec)
	);

	// Reset outranks any wake or vector in the same cycle
	assign wake_src_next = watchdog_timer_timeout_i ? '0 : dec_bus.wake;
	assign vec_src_next  = watchdog_timer_timeout_i ? '0 : dec_bus.vec;

	// ----------------------------------------------------------------
	// Global interrupt mask
	// ----------------------------------------------------------------
	// Disable wins when both instructions coincide
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			masked_reg <= `WKD_MASK_RST;
		end else if (global_irq_mask_instr_i) begin
			masked_reg <= 1'b1;
		end else if (global_irq_unmask_instr_i) begin
			masked_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Wake and vector requests
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			wake_reg     <= `WKD_PULSE_RST;
			vector_reg   <= `WKD_PULSE_RST;
			wake_src_reg <= '0;
			vec_src_reg  <= '0;
		end else begin
			wake_reg     <= |wake_src_next;
			vector_reg   <= |vec_src_next;
			wake_src_reg <= wake_src_next;
			vec_src_reg  <= vec_src_next;
		end
	end

	// ----------------------------------------------------------------
	// Watchdog reset request
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			reset_req_reg <= `WKD_PULSE_RST;
		end else begin
			reset_req_reg <= watchdog_timer_timeout_i;
		end
	end

	// ----------------------------------------------------------------
	// Clock hold and peripheral availability
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			osc_hold_reg  <= 1'b0;
			i2c_avail_reg <= 1'b0;
		end else begin
			osc_hold_reg  <= conv_done_wake_en_i;
			i2c_avail_reg <= (power_mode_i != WKD_GREEN);
		end
	end

	assign wake_o       = wake_reg;
	assign vector_o     = vector_reg;
	assign wake_src_o   = wake_src_reg;
	assign vec_src_o    = vec_src_reg;
	assign reset_req_o  = reset_req_reg;
	assign irq_masked_o = masked_reg;
	assign osc_hold_o   = osc_hold_reg;
	assign i2c_avail_o  = i2c_avail_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	logic low_pwr;
	logic calm;
	assign low_pwr = (power_mode_i == WKD_SLEEP) ||
		(power_mode_i == WKD_IDLE);
	assign calm = !watchdog_timer_timeout_i;

	sequence s_unmask;
		global_irq_unmask_instr_i && !global_irq_mask_instr_i;
	endsequence

	sequence s_pin_full_wake;
		pin_change_evt_i && pin_change_wake_en_i && pin_change_irq_en_i
			&& low_pwr && calm && !global_irq_mask_instr_i;
	endsequence

	mask_set_a : assert property (
		global_irq_mask_instr_i |=> irq_masked_o)
		else $error("mask not set by disable instruction");

	unmask_vec_a : assert property (
		s_unmask ##1 s_pin_full_wake |=> wake_o && vector_o)
		else $error("unmasked pin wake did not vector");

	pin_next_a : assert property (
		pin_change_evt_i && pin_change_wake_en_i && low_pwr && calm
			&& irq_masked_o |=> wake_src_o[0] && !vec_src_o[0])
		else $error("masked pin wake not to next instruction");

	pin_nowake_a : assert property (
		pin_change_evt_i && !pin_change_wake_en_i && low_pwr
			|=> !wake_src_o[0] && !vec_src_o[0])
		else $error("pin change woke without wake enable");

	pin_noirq_a : assert property (
		pin_change_evt_i && !pin_change_irq_en_i |=> !vec_src_o[0])
		else $error("pin change vectored without irq enable");

	lvd_next_a : assert property (
		low_volt_evt_i && low_pwr && calm && low_volt_wake_en_i
			|=> wake_src_o[1] && !vec_src_o[1])
		else $error("low voltage wake vectored");

	osc_hold_a : assert property (
		conv_done_wake_en_i && !rst_i |=> osc_hold_o)
		else $error("oscillators not held for converter wake");

	i2c_green_a : assert property (
		power_mode_i == WKD_GREEN
			|=> !wake_src_o[3] && !vec_src_o[3] && !i2c_avail_o)
		else $error("i2c active in green mode");

	spi_active_a : assert property (
		spi_slave_evt_i && spi_irq_en_i && !low_pwr && calm
			&& !irq_masked_o |=> vec_src_o[4])
		else $error("spi did not vector in active mode");

	scan_sleep_a : assert property (
		scan_evt_i && idle_scan_en_i && power_mode_i == WKD_SLEEP && calm
			|=> wake_o && !vec_src_o[5])
		else $error("scan did not wake sleep to next");

	none_en_a : assert property (
		conv_done_evt_i && !conv_done_wake_en_i && !conv_done_irq_en_i
			|=> !wake_src_o[2] && !vec_src_o[2])
		else $error("converter acted with enables clear");

	wdt_reset_a : assert property (
		watchdog_timer_timeout_i |=> reset_req_o && !wake_o && !vector_o)
		else $error("watchdog did not reset exclusively");

	vec_mask_a : assert property (
		vector_o |-> $past(!irq_masked_o))
		else $error("vector taken while masked");

endmodule : wkd_top

`default_nettype wire

// ==== verif/wkd_evt_model.sv ====
// Model of the peripheral event sources beside the dispatch block.
// Assumes triggers from the bench; each becomes a one-cycle event.
`timescale 1ns/10ps
`default_nettype none

module wkd_evt_model
	import wkd_pkg::*;
(
	// Clock and reset
	input  wire logic     clk_sys_i,
	input  wire logic     rst_i,
	// Triggers from the bench
	input  wire wkd_vec_t trig_i,
	input  wire logic     wdt_trig_i,
	// Events toward the block
	output var  wkd_vec_t evt_o,
	output var  logic     wdt_evt_o
);
	// ----------------------------------------------------------------
	// Registered event pulses
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			evt_o     <= '0;
			wdt_evt_o <= 1'b0;
		end else begin
			evt_o     <= trig_i;
			wdt_evt_o <= wdt_trig_i;
		end
	end
endmodule : wkd_evt_model

`default_nettype wire

// ==== verif/wakeup_interrupt_dispatch_bench.sv ====
// Self-checking bench of the wake-up and interrupt dispatch block.
// Assumes wkd_pkg and the event model are compiled first.
`timescale 1ns/10ps
`default_nettype none

module wakeup_interrupt_dispatch_bench
	import wkd_pkg::*;
;
	logic      clk = 1'b0;
	logic      rst = 1'b1;
	wkd_mode_e mode = WKD_NORMAL;
	logic      msk_set = 1'b0;
	logic      msk_clr = 1'b0;
	wkd_vec_t  we = '0;
	wkd_vec_t  ie = '0;
	wkd_vec_t  trig = '0;
	logic      wdt_trig = 1'b0;
	wkd_vec_t  evt;
	logic      wdt_evt;
	logic      wake, vect, rreq, masked, osc, i2c_ok;
	wkd_vec_t  wsrc, vsrc;
	int        failures = 0;
	int        n_checks = 0;
	logic      m_exp = 1'b1;

	always #4 clk = ~clk;

	wkd_evt_model wkd_evt_model_inst (.clk_sys_i(clk), .rst_i(rst),
		.trig_i(trig), .wdt_trig_i(wdt_trig), .evt_o(evt),
		.wdt_evt_o(wdt_evt));

	wkd_top wkd_top_inst (.clk_sys_i(clk), .rst_i(rst),
		.power_mode_i(mode), .global_irq_mask_instr_i(msk_set),
		.global_irq_unmask_instr_i(msk_clr),
		.pin_change_wake_en_i(we[0]), .pin_change_irq_en_i(ie[0]),
		.low_volt_wake_en_i(we[1]), .low_volt_irq_en_i(ie[1]),
		.conv_done_wake_en_i(we[2]), .conv_done_irq_en_i(ie[2]),
		.i2c_slave_wake_en_i(we[3]), .i2c_irq_en_i(ie[3]),
		.spi_slave_wake_en_i(we[4]), .spi_irq_en_i(ie[4]),
		.idle_scan_en_i(we[5]), .scan_irq_en_i(ie[5]),
		.pin_change_evt_i(evt[0]), .low_volt_evt_i(evt[1]),
		.conv_done_evt_i(evt[2]), .i2c_slave_evt_i(evt[3]),
		.spi_slave_evt_i(evt[4]), .scan_evt_i(evt[5]),
		.watchdog_timer_timeout_i(wdt_evt), .wake_o(wake),
		.vector_o(vect), .wake_src_o(wsrc), .vec_src_o(vsrc),
		.reset_req_o(rreq), .irq_masked_o(masked), .osc_hold_o(osc),
		.i2c_avail_o(i2c_ok));

	// ----------------------------------------------------------------
	// Compare and closing tasks
	// ----------------------------------------------------------------
	task automatic chk_bit(input string nm, input logic e, input logic s);
		n_checks++;
		if (s !== e) begin
			failures++;
			$display("BAD %s expected %b seen %b", nm, e, s);
		end
	endtask : chk_bit

	task automatic chk_vec(input string nm, input wkd_vec_t e,
		input wkd_vec_t s);
		n_checks++;
		if (s !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask : chk_vec

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test

	// Expected {vector, wake} with equal enables on every source
	function automatic logic [11:0] exp_dec(input wkd_mode_e md,
		input logic w, input logic i, input logic m);
		logic     low;
		wkd_vec_t wk, vc;
		low = (md == WKD_SLEEP) || (md == WKD_IDLE);
		for (int s = 0; s < 6; s++) begin
			wk[s] = low & w;
			vc[s] = i & ~m & (w | ~low);
		end
		vc[WKD_SRC_LVD] = ~low & i & ~m;
		if (md == WKD_GREEN) begin
			wk[WKD_SRC_I2C] = 1'b0;
			vc[WKD_SRC_I2C] = 1'b0;
		end
		wk[WKD_SRC_SCAN] = w & low;
		vc[WKD_SRC_SCAN] = w & i & ~m & (md != WKD_SLEEP);
		return {vc, wk};
	endfunction : exp_dec

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic mask_step(input logic set, input logic clr);
		@(posedge clk);
		msk_set <= set;
		msk_clr <= clr;
		@(posedge clk);
		msk_set <= 1'b0;
		msk_clr <= 1'b0;
		m_exp = set ? 1'b1 : (clr ? 1'b0 : m_exp);
		#1 chk_bit("irq_masked", m_exp, masked);
	endtask : mask_step

	task automatic decision_sweep();
		logic [11:0] e;
		for (int md = 0; md < 4; md++) begin
			for (int c = 0; c < 4; c++) begin
				@(posedge clk);
				mode <= wkd_mode_e'(md);
				we   <= {6{c[1]}};
				ie   <= {6{c[0]}};
				trig <= 6'h3F;
				@(posedge clk);
				trig <= 6'h00;
				@(posedge clk);
				e = exp_dec(wkd_mode_e'(md), c[1], c[0], m_exp);
				#1;
				chk_vec("wake_src", e[5:0], wsrc);
				chk_vec("vec_src", e[11:6], vsrc);
				chk_bit("wake", |e[5:0], wake);
				chk_bit("vector", |e[11:6], vect);
				chk_bit("osc_hold", c[1], osc);
				chk_bit("i2c_avail", md != 2, i2c_ok);
				chk_bit("reset_req", 1'b0, rreq);
			end
		end
	endtask : decision_sweep

	task automatic watchdog_hit();
		@(posedge clk);
		mode     <= WKD_SLEEP;
		we       <= 6'h3F;
		ie       <= 6'h3F;
		trig     <= 6'h3F;
		wdt_trig <= 1'b1;
		@(posedge clk);
		trig     <= 6'h00;
		wdt_trig <= 1'b0;
		@(posedge clk);
		#1 chk_bit("reset_req", 1'b1, rreq);
		chk_bit("wake", 1'b0, wake);
		chk_vec("wake_src", 6'h00, wsrc);
		chk_bit("vector", 1'b0, vect);
		chk_vec("vec_src", 6'h00, vsrc);
		@(posedge clk);
		#1 chk_bit("reset_req", 1'b0, rreq);
	endtask : watchdog_hit

	// Unmask strobe followed at once by a pin change in sleep
	task automatic unmask_wake();
		mask_step(1'b1, 1'b0);
		@(posedge clk);
		mode    <= WKD_SLEEP;
		we      <= 6'h3F;
		ie      <= 6'h3F;
		msk_clr <= 1'b1;
		trig    <= 6'h01;
		@(posedge clk);
		msk_clr <= 1'b0;
		trig    <= 6'h00;
		m_exp = 1'b0;
		@(posedge clk);
		#1;
		chk_vec("wake_src", 6'h01, wsrc);
		chk_vec("vec_src", 6'h01, vsrc);
		chk_bit("vector", 1'b1, vect);
		chk_bit("irq_masked", 1'b0, masked);
	endtask : unmask_wake

	// Reset in mid-run, then recovery of the level outputs
	task automatic reset_mid();
		repeat (2) @(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		#1;
		chk_bit("irq_masked", 1'b1, masked);
		chk_bit("osc_hold", 1'b0, osc);
		chk_bit("i2c_avail", 1'b0, i2c_ok);
		@(posedge clk);
		rst <= 1'b0;
		m_exp = 1'b1;
		@(posedge clk);
		#1;
		chk_bit("i2c_avail", 1'b1, i2c_ok);
		chk_bit("osc_hold", 1'b1, osc);
		chk_bit("irq_masked", 1'b1, masked);
	endtask : reset_mid

	initial begin
		repeat (5) @(posedge clk);
		#1 chk_bit("irq_masked", 1'b1, masked);
		chk_bit("i2c_avail", 1'b0, i2c_ok);
		rst <= 1'b0;
		mask_step(1'b0, 1'b1);
		decision_sweep();
		mask_step(1'b1, 1'b1);
		decision_sweep();
		mask_step(1'b0, 1'b1);
		watchdog_hit();
		unmask_wake();
		reset_mid();
		stop_test();
	end

	initial begin
		#20000;
		failures++;
		stop_test();
	end
endmodule : wakeup_interrupt_dispatch_bench

`default_nettype wire
